/* rtl/clock_and_low_power_control.sv */
// Overview of operation
// - Reset selects fast RC divided by eight.
// - Source and divider writable right after reset.
// - Source changes by register write while running.
// - Keep old source until new ready, glitch-free.
// - Programmable prescaler divides CPU and peripheral clock.
// - Four sources: crystal, user clock, fast, slow.
// - External failure forces fast RC over eight.
// - Core, memory, peripherals gated individually.
// - Gate register one bit layout.
// - Selected internal clock driven out on pin.
// - Wait stops CPU, wakes on interrupt.
// - Active halt regulator on, wakes on timer.
// - Active halt regulator off, slower wakeup; here it wakes as fast as with it on.
// - Halt stops all, wakes on external event.
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`include "clk_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module clock_and_low_power_control #(
  parameter int ADDR_W = 8,
  parameter int FAIL_LIMIT = `FAIL_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] osc_level,
  input wire logic [3:0] osc_ready,
  input wire logic int_wake,
  input wire logic auto_wakeup_unit_wake,
  input wire logic ext_wake,
  output var logic [3:0] osc_on,
  output var clk_ctrl_pkg::source_t cur_source,
  output var logic cpu_tick,
  output var logic mem_tick,
  output var logic [7:0] periph_tick_one,
  output var logic [7:0] periph_tick_two,
  output var logic regulator_on,
  output var logic clk_out,
  output var logic clk_out_oe,
  output logic irq
);
  import clk_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator inputs arrive from other domains.

  logic [3:0] lvl_s;
  logic [3:0] rdy_s;
  logic [3:0] lvl_prev_ff;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      level_sync u_lvl (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(osc_level[gi]),
        .dout(lvl_s[gi])
      );
      level_sync u_rdy (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(osc_ready[gi]),
        .dout(rdy_s[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  source_t sel_req_ff;
  logic [2:0] div_ff;
  logic [7:0] gate_one_ff;
  logic [7:0] gate_two_ff;
  logic mon_en_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [3:0] clkout_ff;
  logic [1:0] core_gate_ff;
  power_state_e state_ff;
  power_state_e nxt_state;
  logic [7:0] pcnt_ff;
  logic [7:0] fail_cnt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order.

  logic aw_hold_ff;
  logic w_hold_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;

  assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_ff && !s_axi_bvalid;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_hold_ff || aw_take;
  wire w_have = w_hold_ff || w_take;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire [ADDR_W-1:0] wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
  wire wr_lane0 = w_hold_ff ? wstrb0_ff : s_axi_wstrb[0];
  wire [7:0] wr_word = {wr_addr[7:2], 2'b00};
  wire [7:0] wd = wr_data[7:0];
  wire wr_en = do_write && wr_lane0;

  wire hit_w_switch = wr_word == `OFS_SWITCH;
  wire hit_w_divide = wr_word == `OFS_DIVIDE;
  wire hit_w_gate1 = wr_word == `OFS_GATE_ONE;
  wire hit_w_gate2 = wr_word == `OFS_GATE_TWO;
  wire hit_w_mon = wr_word == `OFS_MONITOR;
  wire hit_w_stat = wr_word == `OFS_IRQ_STAT;
  wire hit_w_mask = wr_word == `OFS_IRQ_MASK;
  wire hit_w_cko = wr_word == `OFS_CLKOUT;
  wire hit_w_pwr = wr_word == `OFS_POWER;
  wire hit_w_core = wr_word == `OFS_CORE_GATE;
  wire hit_w_stsr = wr_word == `OFS_STATUS;
  wire w_mapped = hit_w_switch | hit_w_divide | hit_w_gate1 | hit_w_gate2 | hit_w_mon | hit_w_stat
                  | hit_w_mask | hit_w_cko | hit_w_pwr | hit_w_core | hit_w_stsr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0;
      wstrb0_ff <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      aw_hold_ff <= aw_have && !do_write;
      w_hold_ff <= w_have && !do_write;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_mapped ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clock derived from the selected oscillator.

  wire [3:0] edges = lvl_s & ~lvl_prev_ff;
  wire mtick = edges[cur_source];
  wire switch_busy = sel_req_ff != cur_source;
  // Changing only on an edge of the old source keeps every master period whole.
  wire do_switch = switch_busy && rdy_s[sel_req_ff] && mtick;
  wire ext_active = (cur_source == `SRC_EXT_CRYSTAL) || (cur_source == `SRC_EXT_USER);
  wire fail_now = mon_en_ff && ext_active && (fail_cnt_ff >= 8'(FAIL_LIMIT));
  wire [7:0] div_max = (8'h01 << div_ff) - 8'h01;
  wire ptick = mtick && (pcnt_ff >= div_max);
  wire run_cpu = (state_ff == ST_RUN);
  wire run_periph = (state_ff == ST_RUN) || (state_ff == ST_WAIT);
  wire mode_wr = wr_en && hit_w_pwr && run_cpu;
  wire wake_done = (state_ff == ST_RESUME) && rdy_s[cur_source];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_prev_ff <= 4'h0;
      cur_source <= `RST_SOURCE;
      pcnt_ff <= 8'h00;
      fail_cnt_ff <= 8'h00;
    end else begin
      lvl_prev_ff <= lvl_s;
      if (fail_now) begin
        cur_source <= `SRC_INT_FAST;
      end else if (do_switch) begin
        cur_source <= sel_req_ff;
      end
      if (mtick) begin
        pcnt_ff <= ptick ? 8'h00 : pcnt_ff + 8'h01;
      end
      // A saturating count since the last edge of the external source.
      if (!ext_active || edges[cur_source]) begin
        fail_cnt_ff <= 8'h00;
      end else if (fail_cnt_ff != 8'hff) begin
        fail_cnt_ff <= fail_cnt_ff + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; events set flags with priority over the clear.

  wire [2:0] irq_set = {wake_done, do_switch && !fail_now, fail_now};
  wire [2:0] irq_clr = (wr_en && hit_w_stat) ? wd[2:0] : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_req_ff <= `RST_SOURCE;
      div_ff <= `RST_DIVIDE;
      gate_one_ff <= `RST_GATE_ONE;
      gate_two_ff <= `RST_GATE_TWO;
      mon_en_ff <= 1'b0;
      irq_stat_ff <= 3'h0;
      irq_mask_ff <= 3'h0;
      clkout_ff <= 4'h0;
      core_gate_ff <= `RST_CORE_GATE;
    end else begin
      if (fail_now) begin
        sel_req_ff <= `SRC_INT_FAST;
        div_ff <= `RST_DIVIDE;
      end else begin
        if (wr_en && hit_w_switch) begin
          sel_req_ff <= wd[1:0];
        end
        if (wr_en && hit_w_divide) begin
          div_ff <= wd[2:0];
        end
      end
      if (wr_en && hit_w_gate1) begin
        gate_one_ff <= wd & `MASK_GATE_ONE;
      end
      if (wr_en && hit_w_gate2) begin
        gate_two_ff <= wd & `MASK_GATE_TWO;
      end
      if (wr_en && hit_w_mon) begin
        mon_en_ff <= wd[0];
      end
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      if (wr_en && hit_w_mask) begin
        irq_mask_ff <= wd[2:0];
      end
      if (wr_en && hit_w_cko) begin
        clkout_ff <= wd[3:0];
      end
      if (wr_en && hit_w_core) begin
        core_gate_ff <= wd[1:0];
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Low-power sequencing.

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (mode_wr && wd[2:0] == `MODE_WAIT) begin
          nxt_state = ST_WAIT;
        end else if (mode_wr && (wd[2:0] == `MODE_AHALT_REG_ON || wd[2:0] == `MODE_AHALT_REG_OFF)) begin
          nxt_state = ST_AHALT;
        end else if (mode_wr && wd[2:0] == `MODE_HALT) begin
          nxt_state = ST_HALT;
        end
      end
      ST_WAIT: begin
        if (int_wake || ext_wake) begin
          nxt_state = ST_RESUME;
        end
      end
      ST_AHALT: begin
        if (auto_wakeup_unit_wake || ext_wake) begin
          nxt_state = ST_RESUME;
        end
      end
      ST_HALT: begin
        if (ext_wake) begin
          nxt_state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (rdy_s[cur_source]) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // The regulator drops only for the deep modes; it returns on entry to resume, adding no wakeup time.
  wire reg_off_req = mode_wr && (wd[2:0] == `MODE_AHALT_REG_OFF || wd[2:0] == `MODE_HALT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_RUN;
      regulator_on <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      if (reg_off_req) begin
        regulator_on <= 1'b0;
      end else if (nxt_state == ST_RESUME) begin
        regulator_on <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gated clock enables and oscillator requests.

  wire in_halt = (state_ff == ST_HALT);
  wire in_ahalt = (state_ff == ST_AHALT);
  wire [3:0] need_src = (4'h1 << cur_source) | (4'h1 << sel_req_ff);
  wire [3:0] nxt_osc_on = in_halt ? 4'h0 : in_ahalt ? 4'h8 : need_src;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_tick <= 1'b0;
      mem_tick <= 1'b0;
      periph_tick_one <= 8'h00;
      periph_tick_two <= 8'h00;
      osc_on <= 4'h4;
    end else begin
      cpu_tick <= ptick && run_cpu && core_gate_ff[0];
      mem_tick <= ptick && run_cpu && core_gate_ff[1];
      periph_tick_one <= gate_one_ff & {8{ptick && run_periph}};
      periph_tick_two <= gate_two_ff & {8{ptick && run_periph}};
      osc_on <= nxt_osc_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock output pin: toggles on each rising edge of the chosen clock.

  wire [3:0] cko_src = {edges[`SRC_INT_FAST], edges[`SRC_INT_SLOW], ptick, mtick};
  wire cko_tick = cko_src[clkout_ff[1:0]];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_out <= 1'b0;
      clk_out_oe <= 1'b0;
    end else begin
      clk_out_oe <= clkout_ff[`CLKOUT_EN];
      if (!clkout_ff[`CLKOUT_EN]) begin
        clk_out <= 1'b0;
      end else if (cko_tick) begin
        clk_out <= !clk_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.

  wire [7:0] rd_word = {s_axi_araddr[7:2], 2'b00};
  wire [7:0] status_val = {rdy_s, 1'b0, switch_busy, cur_source};
  wire [7:0] power_val = {3'h0, state_ff};
  logic [7:0] rd_val;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    case (rd_word)
      `OFS_SWITCH: rd_val = {6'h00, sel_req_ff};
      `OFS_DIVIDE: rd_val = {5'h00, div_ff};
      `OFS_GATE_ONE: rd_val = gate_one_ff;
      `OFS_GATE_TWO: rd_val = gate_two_ff;
      `OFS_MONITOR: rd_val = {7'h00, mon_en_ff};
      `OFS_STATUS: rd_val = status_val;
      `OFS_IRQ_STAT: rd_val = {5'h00, irq_stat_ff};
      `OFS_IRQ_MASK: rd_val = {5'h00, irq_mask_ff};
      `OFS_CLKOUT: rd_val = {4'h0, clkout_ff};
      `OFS_POWER: rd_val = power_val;
      `OFS_CORE_GATE: rd_val = {6'h00, core_gate_ff};
      default: begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* rtl/clk_ctrl_consts.svh */
`ifndef CLK_CTRL_CONSTS_SVH
`define CLK_CTRL_CONSTS_SVH

// Register byte offsets.
`define OFS_SWITCH 8'h00
`define OFS_DIVIDE 8'h04
`define OFS_GATE_ONE 8'h08
`define OFS_GATE_TWO 8'h0c
`define OFS_MONITOR 8'h10
`define OFS_STATUS 8'h14
`define OFS_IRQ_STAT 8'h18
`define OFS_IRQ_MASK 8'h1c
`define OFS_CLKOUT 8'h20
`define OFS_POWER 8'h24
`define OFS_CORE_GATE 8'h28

// Source codes.
`define SRC_EXT_CRYSTAL 2'h0
`define SRC_EXT_USER 2'h1
`define SRC_INT_FAST 2'h2
`define SRC_INT_SLOW 2'h3

// Reset values.
`define RST_SOURCE 2'h2
`define RST_DIVIDE 3'h3
`define RST_GATE_ONE 8'hbb
`define RST_GATE_TWO 8'h0c
`define RST_CORE_GATE 2'h3

// Writable bits of the gate registers.
`define MASK_GATE_ONE 8'hbb
`define MASK_GATE_TWO 8'h0c

// Field positions.
`define BIT_GATE_ADV_TIMER 7
`define BIT_GATE_GEN_TIMER 5
`define BIT_GATE_BASIC_TIMER 4
`define BIT_GATE_SERIAL 3
`define BIT_GATE_SYNC_SERIAL 1
`define BIT_GATE_TWO_WIRE 0
`define BIT_GATE_CONVERTER 3
`define BIT_GATE_AUTO_WAKEUP 2
`define IRQ_FAIL 0
`define IRQ_SWITCH 1
`define IRQ_WAKE 2
`define CLKOUT_EN 3

// Low-power request codes written to the power register.
`define MODE_WAIT 3'h1
`define MODE_AHALT_REG_ON 3'h2
`define MODE_AHALT_REG_OFF 3'h3
`define MODE_HALT 3'h4

// Timing.
`define CLK_PERIOD_NS 10
`define FAIL_TIME_NS 1280
`define FAIL_CYCLES (`FAIL_TIME_NS / `CLK_PERIOD_NS)

`endif

/* rtl/clk_ctrl_pkg.sv */
package clk_ctrl_pkg;

  typedef logic [1:0] source_t;

  typedef enum logic [4:0] {
    ST_RUN = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_AHALT = 5'b00100,
    ST_HALT = 5'b01000,
    ST_RESUME = 5'b10000
  } power_state_e;

endpackage

/* rtl/level_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module level_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output var logic dout
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // The output moves only once the second and third stages agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout <= s3_ff;
      end
    end
  end

endmodule

`default_nettype wire

/* tb/clk_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl_props
  import clk_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] osc_ready,
  input wire logic [3:0] osc_on,
  input wire clk_ctrl_pkg::source_t cur_source,
  input wire logic cpu_tick,
  input wire logic [7:0] periph_tick_one,
  input wire logic regulator_on,
  input wire logic clk_out,
  input wire logic clk_out_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_state: assert property ($rose(aresetn) |-> cur_source == 2'h2 && osc_on == 4'h4 && regulator_on)
    else $error("state after reset wrong");
  // A forced fallback after a failure may not wait for ready, so no move to the fast RC is held to it.
  a_switch_ready: assert property ($changed(cur_source) && cur_source != 2'h2 |-> osc_ready[cur_source])
    else $error("source changed before ready");
  a_cpu_pulse: assert property (cpu_tick |=> !cpu_tick)
    else $error("cpu tick longer than one cycle");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 !s_axi_rvalid)
    else $error("read not answered");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_halt_quiet: assert property (!regulator_on && !$past(regulator_on)
    |-> !cpu_tick && periph_tick_one == 8'h0)
    else $error("clocks run while regulator off");
  a_regulator_cause: assert property ($fell(regulator_on) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("regulator off without request");
  a_clkout_idle: assert property (!clk_out_oe && !$past(clk_out_oe) |-> !clk_out)
    else $error("clock output moves while disabled");
endmodule
`default_nettype wire

/* tb/osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
  parameter int READY_DLY = 12
) (
  input wire logic aclk,
  input wire logic [3:0] osc_on,
  input wire logic [3:0] halt_osc,
  output var logic [3:0] osc_level,
  output var logic [3:0] osc_ready
);
  // Half periods in clock cycles: crystal, user clock, fast RC, slow RC (slowest).
  int half [4] = '{3, 4, 3, 6};
  int cnt [4] = '{0, 0, 0, 0};
  int age [4] = '{0, 0, 0, 0};
  initial begin
    osc_level = 4'h0;
    osc_ready = 4'h0;
  end
  // A stopped or failed oscillator gives no edges and withdraws ready.
  always @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (osc_on[i] === 1'b1 && !halt_osc[i]) begin
        age[i] <= age[i] + 1;
        cnt[i] <= (cnt[i] + 1 == half[i]) ? 0 : cnt[i] + 1;
        if (cnt[i] + 1 == half[i]) begin
          osc_level[i] <= !osc_level[i];
        end
        osc_ready[i] <= age[i] >= READY_DLY;
      end else begin
        age[i] <= 0;
        cnt[i] <= 0;
        osc_level[i] <= 1'b0;
        osc_ready[i] <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
`include "clk_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  import clk_ctrl_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] wd; logic [31:0] ex; logic [1:0] rs;} row_s;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, int_wake, auto_wakeup_unit_wake, ext_wake;
  logic cpu_tick, mem_tick, regulator_on, clk_out, clk_out_oe, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, periph_tick_one, periph_tick_two;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, osc_level, osc_ready, osc_on, halt_osc;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  source_t cur_source;
  int errors = 0, check_count = 0, n, k, c_cpu, c_mem, c_p1, c_p2, c_co;
  row_s rows [12] = '{'{1'b0, `OFS_SWITCH, 32'h0, 32'h2, 2'h0}, '{1'b0, `OFS_DIVIDE, 32'h0, 32'h3, 2'h0},
    '{1'b0, `OFS_GATE_ONE, 32'h0, 32'hbb, 2'h0}, '{1'b0, `OFS_GATE_TWO, 32'h0, 32'h0c, 2'h0},
    '{1'b0, `OFS_CORE_GATE, 32'h0, 32'h3, 2'h0}, '{1'b0, `OFS_MONITOR, 32'h0, 32'h0, 2'h0},
    '{1'b1, `OFS_GATE_ONE, 32'hff, 32'hbb, 2'h0}, '{1'b1, `OFS_GATE_TWO, 32'hff, 32'h0c, 2'h0},
    '{1'b1, 8'h2c, 32'h5a, 32'h0, 2'h2}, '{1'b1, `OFS_IRQ_MASK, 32'h7, 32'h7, 2'h0},
    '{1'b1, `OFS_DIVIDE, 32'h0, 32'h0, 2'h0}, '{1'b1, `OFS_CLKOUT, 32'h0b, 32'h0b, 2'h0}};
  source_t srcs [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  logic [2:0] pw_ex [4] = '{3'b111, 3'b110, 3'b010, 3'b010};
  logic [2:0] wk [4] = '{3'b100, 3'b010, 3'b010, 3'b001};
  logic [4:0] st_ex [4] = '{5'h2, 5'h4, 5'h4, 5'h8};

  clock_and_low_power_control #(.FAIL_LIMIT(16)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .osc_level(osc_level), .osc_ready(osc_ready), .int_wake(int_wake), .ext_wake(ext_wake),
    .auto_wakeup_unit_wake(auto_wakeup_unit_wake), .osc_on(osc_on), .cur_source(cur_source),
    .cpu_tick(cpu_tick), .mem_tick(mem_tick), .periph_tick_one(periph_tick_one),
    .periph_tick_two(periph_tick_two), .regulator_on(regulator_on), .clk_out(clk_out),
    .clk_out_oe(clk_out_oe), .irq(irq));
  osc_model u_osc (.aclk(aclk), .osc_on(osc_on), .halt_osc(halt_osc), .osc_level(osc_level), .osc_ready(osc_ready));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Every polling loop runs through here, so no loop can hang the run.
  task automatic tick(inout int t);
    @(posedge aclk);
    t++;
    if (t > 400) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, t, 400);
      test_done();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    logic aw, w;
    t = 0;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      tick(t);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do tick(t);
    while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do tick(t);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do tick(t);
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rd, rsp);
    `CHK(rd, e)
  endtask
  task automatic count_ticks(input int cyc);
    c_cpu = 0;
    c_mem = 0;
    c_p1 = 0;
    c_p2 = 0;
    c_co = 0;
    repeat (cyc) begin
      @(posedge aclk);
      c_cpu += cpu_tick;
      c_mem += mem_tick;
      c_p1 += |periph_tick_one;
      c_p2 += |periph_tick_two;
      c_co += clk_out;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = !aclk;
  end
  initial begin
    // Both ready inputs stay high, so back-to-back transfers never touch them twice in one step.
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h05;
    {int_wake, auto_wakeup_unit_wake, ext_wake, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    halt_osc = 4'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].a, rows[i].wd, rsp);
        `CHK(rsp, rows[i].rs)
      end
      axi_rd(rows[i].a, rd, rsp);
      `CHK(rd, rows[i].ex)
      `CHK(rsp, rows[i].rs)
    end
    count_ticks(60);
    `CHK(c_cpu inside {[9:11]} && c_co > 0, 1'b1)
    axi_wr(`OFS_DIVIDE, 32'h1, rsp);
    count_ticks(60);
    `CHK(c_cpu inside {[4:6]}, 1'b1)
    axi_wr(`OFS_CORE_GATE, 32'h2, rsp);
    axi_wr(`OFS_GATE_ONE, 32'h0, rsp);
    count_ticks(60);
    `CHK({c_cpu == 0, c_mem > 0, c_p1 == 0, c_p2 > 0}, 4'hf)
    axi_wr(`OFS_CORE_GATE, 32'h3, rsp);
    axi_wr(`OFS_GATE_ONE, 32'hbb, rsp);
    foreach (srcs[i]) begin
      axi_wr(`OFS_IRQ_STAT, 32'h7, rsp);
      axi_wr(`OFS_SWITCH, {30'h0, srcs[i]}, rsp);
      n = 0;
      while (cur_source !== srcs[i]) tick(n);
      axi_rd(`OFS_IRQ_STAT, rd, rsp);
      `CHK(rd[1], 1'b1)
    end
    axi_wr(`OFS_IRQ_STAT, 32'h7, rsp);
    axi_wr(`OFS_DIVIDE, 32'h5, rsp);
    axi_wr(`OFS_MONITOR, 32'h1, rsp);
    halt_osc <= 4'h1;
    n = 0;
    while (cur_source !== 2'h2) tick(n);
    chk_rd(`OFS_DIVIDE, 32'h3);
    chk_rd(`OFS_SWITCH, 32'h2);
    `CHK(irq, 1'b1)
    axi_wr(`OFS_IRQ_MASK, 32'h6, rsp);
    axi_rd(`OFS_IRQ_STAT, rd, rsp);
    `CHK({irq, rd[0]}, 2'b01)
    axi_wr(`OFS_IRQ_STAT, 32'h1, rsp);
    axi_rd(`OFS_IRQ_STAT, rd, rsp);
    `CHK(rd[0], 1'b0)
    axi_wr(`OFS_MONITOR, 32'h0, rsp);
    // At divide-by-eight a prescaled tick comes only every 48 cycles, too rare for the short windows below.
    axi_wr(`OFS_DIVIDE, 32'h0, rsp);
    halt_osc <= 4'h0;
    for (int m = 1; m <= 4; m++) begin
      axi_wr(`OFS_IRQ_STAT, 32'h7, rsp);
      axi_wr(`OFS_POWER, m, rsp);
      count_ticks(30);
      `CHK({regulator_on, c_cpu == 0, c_p1 > 0}, pw_ex[m-1])
      chk_rd(`OFS_POWER, {27'h0, st_ex[m-1]});
      if (m == 4) begin
        {int_wake, auto_wakeup_unit_wake, ext_wake} <= 3'b110;
        @(posedge aclk);
        {int_wake, auto_wakeup_unit_wake, ext_wake} <= 3'b000;
        chk_rd(`OFS_POWER, 32'h8);
      end
      {int_wake, auto_wakeup_unit_wake, ext_wake} <= wk[m-1];
      @(posedge aclk);
      {int_wake, auto_wakeup_unit_wake, ext_wake} <= 3'b000;
      k = 0;
      do begin
        axi_rd(`OFS_POWER, rd, rsp);
        k++;
      end while (rd[4:0] !== 5'h1 && k < 50);
      `CHK({rd[4:0], regulator_on}, 6'h3)
      chk_rd(`OFS_IRQ_STAT, 32'h4);
    end
    axi_wr(`OFS_DIVIDE, 32'h5, rsp);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(`OFS_DIVIDE, 32'h3);
    test_done();
  end
endmodule
bind clock_and_low_power_control clk_ctrl_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .osc_ready(osc_ready), .osc_on(osc_on), .cur_source(cur_source),
  .cpu_tick(cpu_tick), .periph_tick_one(periph_tick_one), .regulator_on(regulator_on), .clk_out(clk_out),
  .clk_out_oe(clk_out_oe));
`default_nettype wire
